// ==== src/spipc_top.sv ====
// SPI pin control and bit-rate generator with a classic Wishbone slave
//
// The implementer's own choices: the Wishbone interface to the registers and the register addresses.
module spipc_top
   import spipc_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [3:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Low-power state from the system
   input wire logic wait_mode_i,
   // Select pin request from the shift engine
   input wire logic sel_active_i,
   // Select pin
   input wire logic ss_pin_i,
   output logic ss_pin_o,
   output logic ss_pin_oe_o,
   output logic fault_low_o,
   output logic slave_sel_o,
   // MOSI pin
   input wire logic mosi_pin_i,
   output logic mosi_pin_o,
   output logic mosi_pin_oe_o,
   // MISO pin
   input wire logic miso_pin_i,
   output logic miso_pin_o,
   output logic miso_pin_oe_o,
   // Shift engine data path
   input wire logic tx_bit_i,
   output logic rx_bit_o,
   // Clocking to the shift engine
   output logic bit_tick_o,
   output logic clk_run_o
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] ctrl_two; // spi_control_two
      logic [7:0] bit_rate; // spi_bit_rate_select
      logic [7:0] ctrl_one; // Role and select-output choice
      logic [31:0] rdata; // Registered read data
      logic ack; // Bus acknowledge
      logic [2:0] pre_cnt; // Prescaler count
      logic pre_tick; // Prescaler output tick
      logic [1:0] ss_sync; // Select pin synchroniser
      logic [1:0] mosi_sync; // MOSI pin synchroniser
      logic [1:0] miso_sync; // MISO pin synchroniser
      logic [1:0] wait_sync; // Wait mode sampling
   } spipc_state_t;
   spipc_state_t state_reg, state_next;
   // Decoded fields
   logic fault_en, sw_oe, stop_wait, sw_sel, master, sel_out_mode;
   logic [2:0] prescale_sel, rate_sel;
   logic [7:0] rate_limit; // Rate divisor minus one
   logic clk_run, div_tick, bus_req;
   spipc_ss_use_t ss_use;
   logic [7:0] status_byte;
   assign fault_en = state_reg.ctrl_two[SPIPC_FAULT_EN_BIT];
   assign sw_oe = state_reg.ctrl_two[SPIPC_SW_OE_BIT];
   assign stop_wait = state_reg.ctrl_two[SPIPC_STOP_WAIT_BIT];
   assign sw_sel = state_reg.ctrl_two[SPIPC_SW_SEL_BIT];
   assign master = state_reg.ctrl_one[SPIPC_ROLE_BIT];
   assign sel_out_mode = state_reg.ctrl_one[SPIPC_SEL_OUT_BIT];
   assign prescale_sel = state_reg.bit_rate[SPIPC_PRESCALE_LSB +: 3];
   assign rate_sel = state_reg.bit_rate[SPIPC_RATE_LSB +: 3];
   // ----------------------------------------------------------------
   // Clock gating in wait mode
   // ----------------------------------------------------------------
   // Clocks stop only when wait is seen and stop-in-wait is set
   assign clk_run = !(state_reg.wait_sync[1] && stop_wait);
   // Rate divisor 2^(n+1) expressed as a limit of 2^(n+1)-1
   always_comb begin
      rate_limit = 8'h01;
      case (rate_sel)
         3'h0: rate_limit = 8'h01;
         3'h1: rate_limit = 8'h03;
         3'h2: rate_limit = 8'h07;
         3'h3: rate_limit = 8'h0f;
         3'h4: rate_limit = 8'h1f;
         3'h5: rate_limit = 8'h3f;
         3'h6: rate_limit = 8'h7f;
         3'h7: rate_limit = 8'hff;
         default: rate_limit = 8'h01;
      endcase
   end
   // ----------------------------------------------------------------
   // Select pin use
   // ----------------------------------------------------------------
   always_comb begin
      if (!master) begin
         ss_use = SPIPC_SS_SLAVE_IN;
      end else if (!fault_en) begin
         ss_use = SPIPC_SS_GPIO;
      end else if (sel_out_mode) begin
         ss_use = SPIPC_SS_SEL_OUT;
      end else begin
         ss_use = SPIPC_SS_FAULT_IN;
      end
   end
   // Select pin driven low only while a master select output is active
   assign ss_pin_oe_o = (ss_use == SPIPC_SS_SEL_OUT);
   assign ss_pin_o = !sel_active_i;
   assign fault_low_o = (ss_use == SPIPC_SS_FAULT_IN) && !state_reg.ss_sync[1];
   assign slave_sel_o = (ss_use == SPIPC_SS_SLAVE_IN) && !state_reg.ss_sync[1];
   // ----------------------------------------------------------------
   // Data pin steering
   // ----------------------------------------------------------------
   always_comb begin
      mosi_pin_oe_o = 1'b0;
      miso_pin_oe_o = 1'b0;
      rx_bit_o = 1'b0;
      if (sw_sel) begin
         // Single shared pin; the output enable decides direction
         if (master) begin
            mosi_pin_oe_o = sw_oe;
            rx_bit_o = state_reg.mosi_sync[1];
         end else begin
            miso_pin_oe_o = sw_oe;
            rx_bit_o = state_reg.miso_sync[1];
         end
      end else begin
         // Separate pins; the output enable bit is not looked at
         if (master) begin
            mosi_pin_oe_o = 1'b1;
            rx_bit_o = state_reg.miso_sync[1];
         end else begin
            // Slave drives MISO only while selected
            miso_pin_oe_o = !state_reg.ss_sync[1];
            rx_bit_o = state_reg.mosi_sync[1];
         end
      end
   end
   assign mosi_pin_o = tx_bit_i;
   assign miso_pin_o = tx_bit_i;
   // Status view of pin use, wait mode and clock run
   assign status_byte = {3'h0, state_reg.wait_sync[1], clk_run, sw_sel, ss_use};
   // ----------------------------------------------------------------
   // Next state: bus, prescaler, synchronisers
   // ----------------------------------------------------------------
   assign bus_req = cyc_i && stb_i && !state_reg.ack;
   always_comb begin
      state_next = state_reg;
      state_next.ack = bus_req;
      state_next.ss_sync = {state_reg.ss_sync[0], ss_pin_i};
      state_next.mosi_sync = {state_reg.mosi_sync[0], mosi_pin_i};
      state_next.miso_sync = {state_reg.miso_sync[0], miso_pin_i};
      state_next.wait_sync = {state_reg.wait_sync[0], wait_mode_i};
      // Prescaler: divide bus clock by field value plus one
      state_next.pre_tick = 1'b0;
      if (clk_run) begin
         if (state_reg.pre_cnt >= prescale_sel) begin
            state_next.pre_cnt = 3'h0;
            state_next.pre_tick = 1'b1;
         end else begin
            state_next.pre_cnt = state_reg.pre_cnt + 3'h1;
         end
      end
      // Register access, never blocked by activity
      if (bus_req && we_i && sel_i[0]) begin
         case (adr_i)
            SPIPC_CTRL_TWO_OFS: state_next.ctrl_two = dat_i[7:0] & SPIPC_CTRL_TWO_MASK;
            SPIPC_BIT_RATE_OFS: state_next.bit_rate = dat_i[7:0] & SPIPC_BIT_RATE_MASK;
            SPIPC_CTRL_ONE_OFS: state_next.ctrl_one = dat_i[7:0] & SPIPC_CTRL_ONE_MASK;
            default: state_next.ctrl_two = state_reg.ctrl_two;
         endcase
      end
      if (bus_req) begin
         case (adr_i)
            SPIPC_CTRL_TWO_OFS: state_next.rdata = {24'h0, state_reg.ctrl_two};
            SPIPC_BIT_RATE_OFS: state_next.rdata = {24'h0, state_reg.bit_rate};
            SPIPC_CTRL_ONE_OFS: state_next.rdata = {24'h0, state_reg.ctrl_one};
            SPIPC_STATUS_OFS: state_next.rdata = {24'h0, status_byte};
            default: state_next.rdata = 32'h0;
         endcase
      end
   end
   // State register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= '0;
         state_reg.ctrl_two <= SPIPC_CTRL_TWO_RST;
         state_reg.bit_rate <= SPIPC_BIT_RATE_RST;
         state_reg.ctrl_one <= SPIPC_CTRL_ONE_RST;
         state_reg.ss_sync <= 2'h3;
      end else begin
         state_reg <= state_next;
      end
   end
   // ----------------------------------------------------------------
   // Rate divider after the prescaler
   // ----------------------------------------------------------------
   spipc_divider u_rate (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .tick_i(state_reg.pre_tick && clk_run),
      .limit_i(rate_limit),
      .tick_o(div_tick)
   );
   // Bit tick only offered to a master
   assign bit_tick_o = div_tick && master;
   assign clk_run_o = clk_run;
   assign dat_o = state_reg.rdata;
   assign ack_o = state_reg.ack;
   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   slave_sel_in_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !master |-> !ss_pin_oe_o && !fault_low_o)
      else $error("select pin not input in slave role");
   gpio_release_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (master && !fault_en) |-> (ss_use == SPIPC_SS_GPIO) && !ss_pin_oe_o)
      else $error("select pin not released");
   sel_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (master && fault_en && sel_out_mode) |-> ss_pin_oe_o && (ss_pin_o == !sel_active_i))
      else $error("select output wrong");
   shared_oe_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (sw_sel && master) |-> (mosi_pin_oe_o == sw_oe) && !miso_pin_oe_o)
      else $error("shared pin enable wrong");
   oe_ignored_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (!sw_sel && master) |-> mosi_pin_oe_o)
      else $error("output enable not ignored");
   wait_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (stop_wait && $past(wait_mode_i, 2) && $past(wait_mode_i)) |-> !clk_run_o)
      else $error("clocks run in wait");
   slave_shared_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (sw_sel && !master) |-> !mosi_pin_oe_o && (rx_bit_o == state_reg.miso_sync[1]))
      else $error("slave shared pin wrong");
   sep_pins_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (!sw_sel && master) |-> (rx_bit_o == state_reg.miso_sync[1]))
      else $error("separate pins wrong");
   // Looks back from the second tick, so a later rate change or stop cannot trip it
   fast_rate_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (master && clk_run && state_reg.bit_rate == 8'h00 && $past(clk_run)
       && $past(state_reg.bit_rate) == 8'h00 && $past(clk_run, 2)
       && $past(state_reg.bit_rate, 2) == 8'h00 && $past(bit_tick_o, 2))
      |-> bit_tick_o && !$past(bit_tick_o))
      else $error("bit tick period not two");
   bus_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (cyc_i && stb_i && !ack_o) |=> ack_o)
      else $error("bus not answered");
endmodule

// ==== src/spipc_pkg.sv ====
// Package of register offsets, field positions and reset values for the SPI pin control block
package spipc_pkg;
   // ----------------------------------------------------------------
   // Register map (byte addresses, one aligned word each)
   // ----------------------------------------------------------------
   localparam logic [3:0] SPIPC_CTRL_TWO_OFS = 4'h0; // spi_control_two
   localparam logic [3:0] SPIPC_BIT_RATE_OFS = 4'h4; // spi_bit_rate_select
   localparam logic [3:0] SPIPC_CTRL_ONE_OFS = 4'h8; // Role and select-output choice
   localparam logic [3:0] SPIPC_STATUS_OFS = 4'hc; // Pin-use, wait and clock-run status
   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int SPIPC_FAULT_EN_BIT = 4;
   localparam int SPIPC_SW_OE_BIT = 3;
   localparam int SPIPC_STOP_WAIT_BIT = 1;
   localparam int SPIPC_SW_SEL_BIT = 0;
   localparam int SPIPC_PRESCALE_LSB = 4;
   localparam int SPIPC_RATE_LSB = 0;
   localparam int SPIPC_ROLE_BIT = 0;
   localparam int SPIPC_SEL_OUT_BIT = 1;
   // ----------------------------------------------------------------
   // Reset values and write masks
   // ----------------------------------------------------------------
   localparam logic [7:0] SPIPC_CTRL_TWO_RST = 8'h00;
   localparam logic [7:0] SPIPC_BIT_RATE_RST = 8'h00;
   localparam logic [7:0] SPIPC_CTRL_ONE_RST = 8'h00;
   localparam logic [7:0] SPIPC_CTRL_TWO_MASK = 8'h1b;
   localparam logic [7:0] SPIPC_BIT_RATE_MASK = 8'h77;
   localparam logic [7:0] SPIPC_CTRL_ONE_MASK = 8'h03;
   // ----------------------------------------------------------------
   // Pin-use encodings for the select pin
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      SPIPC_SS_SLAVE_IN,
      SPIPC_SS_GPIO,
      SPIPC_SS_FAULT_IN,
      SPIPC_SS_SEL_OUT
   } spipc_ss_use_t;
endpackage

// ==== src/spipc_divider.sv ====
// Divide-by-N counter giving a one-cycle tick every N input ticks
module spipc_divider
   import spipc_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Count control
   input wire logic tick_i,
   input wire logic [7:0] limit_i,
   // Output tick
   output logic tick_o
);
   typedef struct packed {
      logic [7:0] cnt; // Ticks seen so far
   } spipc_div_state_t;
   spipc_div_state_t state_reg, state_next;
   logic wrap;
   // Wrap when the count meets the limit (divisor minus one)
   always_comb begin
      state_next = state_reg;
      wrap = tick_i && (state_reg.cnt >= limit_i);
      if (wrap) begin
         state_next.cnt = 8'h00;
      end else if (tick_i) begin
         state_next.cnt = state_reg.cnt + 8'h01;
      end
   end
   // State register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end
   assign tick_o = wrap;
endmodule

// ==== bench/spipc_far_end.sv ====
// Far-side SPI device model sharing the select and data pins
module spipc_far_end (
   // Levels the far device puts on lines the block releases
   input wire logic ss_level_i,
   input wire logic data_bit_i,
   // Block pin drivers
   input wire logic ss_drv_i,
   input wire logic ss_oe_i,
   input wire logic mosi_drv_i,
   input wire logic mosi_oe_i,
   input wire logic miso_drv_i,
   input wire logic miso_oe_i,
   // Resolved wire levels
   output logic ss_wire_o,
   output logic mosi_wire_o,
   output logic miso_wire_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // The far device drives every line the block leaves free, so no wire floats
   always_comb begin
      ss_wire_o = ss_oe_i ? ss_drv_i : ss_level_i;
      mosi_wire_o = mosi_oe_i ? mosi_drv_i : data_bit_i;
      miso_wire_o = miso_oe_i ? miso_drv_i : data_bit_i;
   end
endmodule

// ==== bench/testbench.sv ====
// Self-checking bench for the SPI pin control and bit-rate block
module testbench;
   import spipc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic [3:0] adr_i = 4'h0, sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0, dat_o, rd;
   logic ack_o, wait_mode_i = 1'b0, sel_active_i = 1'b0, ss_level = 1'b1, bit_v = 1'b0;
   logic tx_bit_i = 1'b0, ss_pin_i, ss_pin_o, ss_pin_oe_o, fault_low_o, slave_sel_o;
   logic mosi_pin_i, mosi_pin_o, mosi_pin_oe_o, miso_pin_i, miso_pin_o, miso_pin_oe_o;
   logic rx_bit_o, bit_tick_o, clk_run_o;
   int err_count = 0, num_checks = 0, gap;
   // 40 MHz bus clock
   always #12.5 clk_i = ~clk_i;
   spipc_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
      .ack_o(ack_o), .wait_mode_i(wait_mode_i), .sel_active_i(sel_active_i),
      .ss_pin_i(ss_pin_i), .ss_pin_o(ss_pin_o), .ss_pin_oe_o(ss_pin_oe_o),
      .fault_low_o(fault_low_o), .slave_sel_o(slave_sel_o), .mosi_pin_i(mosi_pin_i),
      .mosi_pin_o(mosi_pin_o), .mosi_pin_oe_o(mosi_pin_oe_o), .miso_pin_i(miso_pin_i),
      .miso_pin_o(miso_pin_o), .miso_pin_oe_o(miso_pin_oe_o), .tx_bit_i(tx_bit_i),
      .rx_bit_o(rx_bit_o), .bit_tick_o(bit_tick_o), .clk_run_o(clk_run_o));
   spipc_far_end u_far (.ss_level_i(ss_level), .data_bit_i(bit_v), .ss_drv_i(ss_pin_o),
      .ss_oe_i(ss_pin_oe_o), .mosi_drv_i(mosi_pin_o), .mosi_oe_i(mosi_pin_oe_o),
      .miso_drv_i(miso_pin_o), .miso_oe_i(miso_pin_oe_o), .ss_wire_o(ss_pin_i),
      .mosi_wire_o(mosi_pin_i), .miso_wire_o(miso_pin_i));
   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic complete_run();
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Classic cycle: hold until ack, release at that edge
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      sel_i <= 4'hf;
      dat_i <= d;
      // No cycle limit here; only the watchdog ends a wait for ack
      do begin
         @(posedge clk_i);
      end while (ack_o !== 1'b1);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
   endtask
   // Settle through the two-stage pin synchronisers
   task automatic settle();
      repeat (4) @(posedge clk_i);
   endtask
   task automatic rx_chk(input logic b);
      bit_v <= b;
      settle();
      chk(32'(rx_bit_o), 32'(b));
   endtask
   // Cycles between two master bit ticks, bounded
   task automatic tick_gap(output int n);
      int k;
      for (k = 0; k < 3000 && bit_tick_o !== 1'b1; k++) @(posedge clk_i);
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (bit_tick_o !== 1'b1 && n < 3000);
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic regs_case();
      wb(0, SPIPC_CTRL_TWO_OFS, 0); chk(rd, 32'h0);
      wb(0, SPIPC_BIT_RATE_OFS, 0); chk(rd, 32'h0);
      wb(1, SPIPC_CTRL_TWO_OFS, 32'hff); wb(0, SPIPC_CTRL_TWO_OFS, 0); chk(rd, 32'h1b);
      wb(1, SPIPC_BIT_RATE_OFS, 32'hff); wb(0, SPIPC_BIT_RATE_OFS, 0); chk(rd, 32'h77);
   endtask
   task automatic select_case();
      wb(1, SPIPC_CTRL_ONE_OFS, 0); wb(1, SPIPC_CTRL_TWO_OFS, 32'h10);
      ss_level <= 1'b0; settle();
      wb(0, SPIPC_STATUS_OFS, 0); chk(rd & 32'h3, 32'h0);
      chk(32'({slave_sel_o, ss_pin_oe_o}), 32'h2);
      wb(1, SPIPC_CTRL_ONE_OFS, 1); wb(1, SPIPC_CTRL_TWO_OFS, 0);
      wb(0, SPIPC_STATUS_OFS, 0); chk(rd & 32'h3, 32'h1);
      chk(32'({fault_low_o, ss_pin_oe_o}), 32'h0);
      wb(1, SPIPC_CTRL_TWO_OFS, 32'h10); settle();
      wb(0, SPIPC_STATUS_OFS, 0); chk(rd & 32'h3, 32'h2);
      chk(32'(fault_low_o), 32'h1);
      wb(1, SPIPC_CTRL_ONE_OFS, 3); sel_active_i <= 1'b1; settle();
      wb(0, SPIPC_STATUS_OFS, 0); chk(rd & 32'h3, 32'h3);
      chk(32'({ss_pin_oe_o, ss_pin_o}), 32'h2);
      sel_active_i <= 1'b0; ss_level <= 1'b1; settle();
      chk(32'({ss_pin_oe_o, ss_pin_o}), 32'h3);
   endtask
   task automatic data_case();
      wb(1, SPIPC_CTRL_ONE_OFS, 1); wb(1, SPIPC_CTRL_TWO_OFS, 32'h08); tx_bit_i <= 1'b1;
      settle(); chk(32'({mosi_pin_oe_o, miso_pin_oe_o, mosi_pin_o}), 32'h5);
      rx_chk(1'b1); rx_chk(1'b0);
      // Output enable cleared: a separate-pin master still drives MOSI
      wb(1, SPIPC_CTRL_TWO_OFS, 32'h00);
      settle();
      chk(32'({mosi_pin_oe_o, miso_pin_oe_o}), 32'h2);
      wb(1, SPIPC_CTRL_TWO_OFS, 32'h09); settle();
      chk(32'({mosi_pin_oe_o, miso_pin_oe_o}), 32'h2);
      wb(1, SPIPC_CTRL_TWO_OFS, 32'h01); settle();
      chk(32'(mosi_pin_oe_o), 32'h0);
      rx_chk(1'b1); rx_chk(1'b0);
      wb(1, SPIPC_CTRL_ONE_OFS, 0); wb(1, SPIPC_CTRL_TWO_OFS, 32'h09); settle();
      chk(32'({mosi_pin_oe_o, miso_pin_oe_o, miso_pin_o}), 32'h3);
      wb(1, SPIPC_CTRL_TWO_OFS, 32'h01); settle();
      rx_chk(1'b1); rx_chk(1'b0);
      tx_bit_i <= 1'b0;
   endtask
   task automatic rate_case(input int p, input int r);
      wb(1, SPIPC_BIT_RATE_OFS, 32'((p << 4) | r));
      tick_gap(gap); tick_gap(gap);
      chk(32'(gap), 32'((p + 1) * (2 << r)));
   endtask
   task automatic wait_case();
      int k, n;
      wb(1, SPIPC_BIT_RATE_OFS, 32'h10);
      wb(1, SPIPC_CTRL_TWO_OFS, 0);
      wait_mode_i <= 1'b1;
      settle();
      chk(32'(clk_run_o), 32'h1);
      // Prescale two, rate two: a tick every four clocks while running
      tick_gap(gap);
      tick_gap(gap);
      chk(32'(gap), 32'h4);
      wb(1, SPIPC_CTRL_TWO_OFS, 32'h02); settle();
      chk(32'(clk_run_o), 32'h0);
      n = 0;
      for (k = 0; k < 50; k++) begin
         @(posedge clk_i);
         if (bit_tick_o === 1'b1) n++;
      end
      chk(32'(n), 32'h0);
      wait_mode_i <= 1'b0; settle();
      chk(32'(clk_run_o), 32'h1);
   endtask
   // ------------------------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      regs_case();
      select_case();
      data_case();
      // Bit ticks only reach a master, so the rate sweeps run in that role
      wb(1, SPIPC_CTRL_ONE_OFS, 1);
      for (int p = 0; p < 8; p++) rate_case(p, 0);
      for (int r = 0; r < 8; r++) rate_case(1, r);
      wait_case();
      complete_run();
   end
   // Cuts a hang short well beyond the expected run length
   initial begin
      repeat (90000) @(posedge clk_i);
      err_count++;
      complete_run();
   end
endmodule
